// File: rtl/fsa_map.vh
`ifndef FSA_MAP_VH
`define FSA_MAP_VH

// Flash size in kilobytes; one, two or three sectors follow from it
`define FSA_FLASH_KB 16
`define FSA_FLASH_BASE 16'hC000
`define FSA_MEM_AW 14
`define FSA_MEM_DEPTH 16384

// Sector address ranges
`define FSA_SEC0_LO 16'hF000
`define FSA_SEC0_HI 16'hFFFF
`define FSA_SEC1_LO 16'hE000
`define FSA_SEC1_HI 16'hEFFF
`define FSA_SEC2_LO 16'hC000
`define FSA_SEC2_HI 16'hDFFF

// Operation codes, shared by the local port and the link frame
`define FSA_OP_READ 3'h0
`define FSA_OP_PROG 3'h1
`define FSA_OP_ERASE_SEC 3'h2
`define FSA_OP_ERASE_ALL 3'h3
`define FSA_OP_OPTION 3'h4
`define FSA_OP_TEST_WR 3'h5
`define FSA_OP_TEST_RUN 3'h6
`define FSA_OP_KEY 3'h7

// Guard keys, arbitrary values
`define FSA_KEY1 8'h56
`define FSA_KEY2 8'hAE

// Option byte
`define FSA_OPT_RESET 8'h00
`define FSA_OPT_LOCK_BIT 0
`define FSA_ERASED 8'hFF

// Link framing
`define FSA_FRAME_BITS 6'd32
`define FSA_TX_BITS 4'd8
`define FSA_STRAP_WAIT 2'd3

`endif

// File: rtl/fsa_mem.v
`timescale 1ns/1ps
`include "fsa_map.vh"

module fsa_mem (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire we,
   input wire [`FSA_MEM_AW-1:0] addr,
   input wire [7:0] wdata,
   output reg [7:0] rdata
);
   reg [7:0] mem [0:`FSA_MEM_DEPTH-1];

   // Byte array, write before read never mixed: registered read of old data
   always @(posedge clk) begin
      if (ce && we) begin
         mem[addr] <= wdata;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (ce) begin
         rdata <= mem[addr];
      end
   end
endmodule

// File: rtl/fsa_flash_access.v
// Functional notes
// - Sectors 0 and 1 are 4 KB each
// - Sector 0 spans F000 to FFFF, holding vectors
// - One, two or three sectors by flash size
// - Erase whole array or one sector only
// - Byte programming, program/erase need programming voltage
// - Self-programming mode never touches sector 0
// - Programmer and link modes reach everything, options too
// - Read lock hides contents from the link and blocks link writes
// - Clearing read lock erases whole array first
// - Lock follows dedicated option byte bit
// - Key sequence guards every program or erase
// - Link uses one clock, one two-way data pin
// - Attached tool takes link pins from application
// - Link test mode loads and runs RAM patterns
`timescale 1ns/1ps
`include "fsa_map.vh"

module fsa_flash_access (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire standalone_mode,
   input wire tool_attached,
   input wire prog_select_voltage_pin,
   input wire link_serial_clock_pin,
   input wire link_serial_data_pin_i,
   output reg link_serial_data_pin_o,
   output reg link_serial_data_pin_oe,
   output wire app_link_pins_free,
   output reg incircuit_link_mode,
   output wire read_lock_active,
   input wire cpu_req,
   input wire [2:0] cpu_op,
   input wire [15:0] cpu_addr,
   input wire [7:0] cpu_wdata,
   output wire cpu_ready,
   output reg cpu_done,
   output reg cpu_err,
   output reg [7:0] cpu_rdata,
   output reg [7:0] option_byte,
   output reg test_ram_we,
   output reg [7:0] test_ram_addr,
   output reg [7:0] test_ram_data,
   output reg test_run
);
   localparam ST_IDLE = 3'd0;
   localparam ST_READ = 3'd1;
   localparam ST_RDATA = 3'd2;
   localparam ST_ERASE = 3'd3;
   localparam ST_OPT = 3'd4;
   localparam NUM_SECTORS = (`FSA_FLASH_KB <= 4) ? 2'd1 : (`FSA_FLASH_KB <= 8) ? 2'd2 : 2'd3;

   reg [2:0] state;
   reg src_link;
   reg [15:0] ecur;
   reg [15:0] eend;
   reg [7:0] opt_new;
   reg [1:0] guard;
   reg [1:0] strap_cnt;
   reg ls_s1, ls_s2, ls_s3, ld_s1, ld_s2, ta_s1, ta_s2, vp_s1, vp_s2;
   reg [31:0] rx_sr;
   reg [5:0] rx_cnt;
   reg link_pend;
   reg [7:0] tx_sr;
   reg [3:0] tx_cnt;
   reg mem_we;
   reg [15:0] mem_a;
   reg [7:0] mem_wd;
   wire [7:0] mem_rd;
   wire take_link, take_cpu, take, l_rise, l_fall, vpp_ok;
   wire [2:0] r_op;
   wire [15:0] r_addr;
   wire [7:0] r_data;
   reg [1:0] sec;
   reg sec_ok, refuse;
   reg [15:0] sec_lo, sec_hi;

   // Pin inputs pass two flip-flops first
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ls_s1 <= 1'b0;
         ls_s2 <= 1'b0;
         ls_s3 <= 1'b0;
         ld_s1 <= 1'b0;
         ld_s2 <= 1'b0;
         ta_s1 <= 1'b0;
         ta_s2 <= 1'b0;
         vp_s1 <= 1'b0;
         vp_s2 <= 1'b0;
      end else if (ce) begin
         ls_s1 <= link_serial_clock_pin;
         ls_s2 <= ls_s1;
         ls_s3 <= ls_s2;
         ld_s1 <= link_serial_data_pin_i;
         ld_s2 <= ld_s1;
         ta_s1 <= tool_attached;
         ta_s2 <= ta_s1;
         vp_s1 <= prog_select_voltage_pin;
         vp_s2 <= vp_s1;
      end
   end

   assign l_rise = ls_s2 & ~ls_s3;
   assign l_fall = ~ls_s2 & ls_s3;
   assign vpp_ok = vp_s2;
   assign app_link_pins_free = ~ta_s2;
   assign read_lock_active = option_byte[`FSA_OPT_LOCK_BIT];

   // Link mode latched from the voltage pin shortly after reset release
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         strap_cnt <= 2'd0;
         incircuit_link_mode <= 1'b0;
      end else if (ce && strap_cnt != `FSA_STRAP_WAIT) begin
         strap_cnt <= strap_cnt + 2'd1;
         if (strap_cnt == `FSA_STRAP_WAIT - 2'd1) begin
            incircuit_link_mode <= vp_s2;
         end
      end
   end

   // Frame: op byte, address high, address low, data; sampled on rising edges
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_sr <= 32'h0000_0000;
         rx_cnt <= 6'd0;
         link_pend <= 1'b0;
      end else if (ce) begin
         if (take_link) begin
            link_pend <= 1'b0;
         end
         if (incircuit_link_mode && ta_s2 && l_rise && tx_cnt == 4'd0 &&
               !link_serial_data_pin_oe) begin
            rx_sr <= {rx_sr[30:0], ld_s2};
            if (rx_cnt == `FSA_FRAME_BITS - 6'd1) begin
               rx_cnt <= 6'd0;
               link_pend <= 1'b1;
            end else begin
               rx_cnt <= rx_cnt + 6'd1;
            end
         end
      end
   end

   assign take_link = ce && state == ST_IDLE && link_pend;
   assign take_cpu = ce && state == ST_IDLE && !link_pend && cpu_req;
   assign take = take_link | take_cpu;
   assign cpu_ready = state == ST_IDLE && !link_pend;
   assign r_op = take_link ? rx_sr[26:24] : cpu_op;
   assign r_addr = take_link ? rx_sr[23:8] : cpu_addr;
   assign r_data = take_link ? rx_sr[7:0] : cpu_wdata;

   // Sector decode
   always @* begin
      sec = 2'd0;
      sec_ok = 1'b1;
      sec_lo = `FSA_SEC0_LO;
      sec_hi = `FSA_SEC0_HI;
      if (r_addr >= `FSA_SEC0_LO) begin
         sec = 2'd0;
      end else if (r_addr >= `FSA_SEC1_LO && NUM_SECTORS > 2'd1) begin
         sec = 2'd1;
         sec_lo = `FSA_SEC1_LO;
         sec_hi = `FSA_SEC1_HI;
      end else if (r_addr >= `FSA_SEC2_LO && NUM_SECTORS > 2'd2) begin
         sec = 2'd2;
         sec_lo = `FSA_SEC2_LO;
         sec_hi = `FSA_SEC2_HI;
      end else begin
         sec_ok = 1'b0;
      end
   end

   // Permission check for the request being taken
   always @* begin
      refuse = 1'b0;
      case (r_op)
         `FSA_OP_READ: begin
            refuse = !sec_ok || (take_link && read_lock_active);
         end
         `FSA_OP_PROG, `FSA_OP_ERASE_SEC: begin
            refuse = !sec_ok || !vpp_ok || guard != 2'd2;
            if (!take_link && !standalone_mode && sec == 2'd0) begin
               refuse = 1'b1;
            end
            if (take_link && read_lock_active) begin
               refuse = 1'b1;
            end
         end
         `FSA_OP_ERASE_ALL: begin
            refuse = !vpp_ok || guard != 2'd2 || !(take_link || standalone_mode);
            if (take_link && read_lock_active) begin
               refuse = 1'b1;
            end
         end
         `FSA_OP_OPTION: begin
            refuse = !vpp_ok || guard != 2'd2 || !(take_link || standalone_mode);
         end
         `FSA_OP_TEST_WR, `FSA_OP_TEST_RUN: begin
            refuse = !take_link;
         end
         default: begin
            refuse = 1'b0;
         end
      endcase
   end

   // Operation engine
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
         src_link <= 1'b0;
         ecur <= 16'h0000;
         eend <= 16'h0000;
         opt_new <= 8'h00;
         guard <= 2'd0;
         option_byte <= `FSA_OPT_RESET;
         cpu_done <= 1'b0;
         cpu_err <= 1'b0;
         cpu_rdata <= 8'h00;
         test_ram_we <= 1'b0;
         test_ram_addr <= 8'h00;
         test_ram_data <= 8'h00;
         test_run <= 1'b0;
         tx_sr <= 8'h00;
         tx_cnt <= 4'd0;
         link_serial_data_pin_o <= 1'b0;
         link_serial_data_pin_oe <= 1'b0;
      end else if (ce) begin
         cpu_done <= 1'b0;
         cpu_err <= 1'b0;
         test_ram_we <= 1'b0;
         test_run <= 1'b0;
         if (tx_cnt != 4'd0 && l_fall) begin
            link_serial_data_pin_o <= tx_sr[7];
            link_serial_data_pin_oe <= 1'b1;
            tx_sr <= {tx_sr[6:0], 1'b0};
            tx_cnt <= tx_cnt - 4'd1;
         end else if (tx_cnt == 4'd0 && l_fall) begin
            link_serial_data_pin_oe <= 1'b0;
         end
         case (state)
            ST_IDLE: begin
               if (take) begin
                  src_link <= take_link;
                  if (r_op != `FSA_OP_KEY && r_op != `FSA_OP_READ) begin
                     guard <= 2'd0;
                  end
                  if (refuse) begin
                     cpu_err <= !take_link;
                     if (take_link && r_op == `FSA_OP_READ) begin
                        tx_sr <= 8'h00;
                        tx_cnt <= `FSA_TX_BITS;
                     end
                  end else begin
                     case (r_op)
                        `FSA_OP_READ: begin
                           ecur <= r_addr;
                           state <= ST_READ;
                        end
                        `FSA_OP_PROG: begin
                           cpu_done <= !take_link;
                        end
                        `FSA_OP_ERASE_SEC: begin
                           ecur <= sec_lo;
                           eend <= sec_hi;
                           opt_new <= option_byte;
                           state <= ST_ERASE;
                        end
                        `FSA_OP_ERASE_ALL: begin
                           ecur <= `FSA_FLASH_BASE;
                           eend <= 16'hFFFF;
                           opt_new <= option_byte;
                           state <= ST_ERASE;
                        end
                        `FSA_OP_OPTION: begin
                           opt_new <= r_data;
                           if (read_lock_active && !r_data[`FSA_OPT_LOCK_BIT]) begin
                              ecur <= `FSA_FLASH_BASE;
                              eend <= 16'hFFFF;
                              state <= ST_ERASE;
                           end else begin
                              state <= ST_OPT;
                           end
                        end
                        `FSA_OP_TEST_WR: begin
                           test_ram_we <= 1'b1;
                           test_ram_addr <= r_addr[7:0];
                           test_ram_data <= r_data;
                        end
                        `FSA_OP_TEST_RUN: begin
                           test_run <= 1'b1;
                        end
                        default: begin
                           if (guard == 2'd0 && r_data == `FSA_KEY1) begin
                              guard <= 2'd1;
                           end else if (guard == 2'd1 && r_data == `FSA_KEY2) begin
                              guard <= 2'd2;
                           end else begin
                              guard <= 2'd0;
                           end
                           cpu_done <= !take_link;
                        end
                     endcase
                  end
               end
            end
            ST_READ: begin
               state <= ST_RDATA;
            end
            ST_RDATA: begin
               if (src_link) begin
                  tx_sr <= mem_rd;
                  tx_cnt <= `FSA_TX_BITS;
               end else begin
                  cpu_rdata <= mem_rd;
                  cpu_done <= 1'b1;
               end
               state <= ST_IDLE;
            end
            ST_ERASE: begin
               if (ecur == eend) begin
                  state <= ST_OPT;
               end else begin
                  ecur <= ecur + 16'h0001;
               end
            end
            ST_OPT: begin
               option_byte <= opt_new;
               cpu_done <= !src_link;
               state <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Memory port steering
   always @* begin
      mem_we = 1'b0;
      mem_a = r_addr;
      mem_wd = r_data;
      if (state == ST_ERASE) begin
         mem_we = 1'b1;
         mem_a = ecur;
         mem_wd = `FSA_ERASED;
      end else if (state != ST_IDLE) begin
         mem_a = ecur;
      end else if (take && !refuse && r_op == `FSA_OP_PROG) begin
         mem_we = 1'b1;
      end
   end

   // Hold read address in ecur during the read states
   fsa_mem u_mem (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .we(mem_we),
      .addr(mem_a[`FSA_MEM_AW-1:0]),
      .wdata(mem_wd),
      .rdata(mem_rd)
   );
endmodule

// File: testbench/fsa_monitor.sv
`timescale 1ns/1ps
`include "fsa_map.vh"
module fsa_monitor (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire standalone_mode,
   input wire tool_attached,
   input wire prog_select_voltage_pin,
   input wire link_serial_data_pin_oe,
   input wire app_link_pins_free,
   input wire incircuit_link_mode,
   input wire read_lock_active,
   input wire cpu_req,
   input wire [2:0] cpu_op,
   input wire [15:0] cpu_addr,
   input wire cpu_ready,
   input wire cpu_done,
   input wire cpu_err,
   input wire [7:0] option_byte
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   wire take = ce && cpu_req && cpu_ready;
   a_read_latency: assert property (take && cpu_op == `FSA_OP_READ && cpu_addr >= 16'hC000 |-> ##3 cpu_done)
      else $error("flash read not answered in three cycles");
   a_low_addr_err: assert property (take && cpu_op == `FSA_OP_READ && cpu_addr < 16'hC000 |-> ##1 cpu_err)
      else $error("read below flash not refused");
   a_sec0_protect: assert property (take && cpu_op == `FSA_OP_PROG && cpu_addr >= 16'hF000 && !standalone_mode |-> ##1 cpu_err)
      else $error("first sector written in self-programming");
   a_priv_ops: assert property (take && (cpu_op == `FSA_OP_ERASE_ALL || cpu_op == `FSA_OP_OPTION) && !standalone_mode |-> ##1 cpu_err)
      else $error("privileged operation not refused");
   a_novolt_refuse: assert property ((!prog_select_voltage_pin) [*4] ##0 (take && cpu_op == `FSA_OP_PROG) |-> ##1 cpu_err)
      else $error("program accepted without voltage");
   a_lock_follows: assert property ($changed(read_lock_active) |-> cpu_done || incircuit_link_mode)
      else $error("lock changed without option write");
   a_opt_privileged: assert property ($changed(option_byte) |-> $past(standalone_mode) || incircuit_link_mode)
      else $error("option byte changed in self-programming");
   a_pins_claimed: assert property (tool_attached [*4] |-> !app_link_pins_free)
      else $error("link pins left to application");
   a_reply_mode: assert property ($rose(link_serial_data_pin_oe) |-> incircuit_link_mode && tool_attached)
      else $error("data pin driven outside link mode");
   a_test_ops_cpu: assert property (take && (cpu_op == `FSA_OP_TEST_WR || cpu_op == `FSA_OP_TEST_RUN) |-> ##1 cpu_err)
      else $error("test operation accepted from cpu");
   c_erase_sec: cover property (take && cpu_op == `FSA_OP_ERASE_SEC);
   c_reply: cover property (incircuit_link_mode && $rose(link_serial_data_pin_oe));
   c_locked: cover property (read_lock_active);
endmodule
bind fsa_flash_access fsa_monitor u_fsa_monitor (.clk(clk), .rst(rst), .ce(ce),
   .standalone_mode(standalone_mode), .tool_attached(tool_attached),
   .prog_select_voltage_pin(prog_select_voltage_pin),
   .link_serial_data_pin_oe(link_serial_data_pin_oe), .app_link_pins_free(app_link_pins_free),
   .incircuit_link_mode(incircuit_link_mode), .read_lock_active(read_lock_active),
   .cpu_req(cpu_req), .cpu_op(cpu_op), .cpu_addr(cpu_addr), .cpu_ready(cpu_ready),
   .cpu_done(cpu_done), .cpu_err(cpu_err), .option_byte(option_byte));

// File: testbench/fsa_tool_model.sv
`timescale 1ns/1ps
module fsa_tool_model (
   input wire dev_o,
   input wire dev_oe,
   output reg sclk,
   output wire sdata
);
   reg tool_oe;
   reg tool_d;
   // One clock, one shared data line; a released line shows the inverse bit
   assign sdata = dev_oe ? dev_o : (tool_oe ? tool_d : ~dev_o);
   initial begin
      sclk = 1'b0;
      tool_oe = 1'b1;
      tool_d = 1'b0;
   end
   // Clock runs only inside frames, bits MSB first, data changes while low
   task frame(input [31:0] f, input rd, output [7:0] r);
      integer i;
      begin
         r = 8'h00;
         for (i = 31; i >= 0; i = i - 1) begin
            sclk = 1'b0;
            tool_d = f[i];
            #100 sclk = 1'b1;
            #100;
         end
         if (rd) begin
            tool_oe = 1'b0;
            #400;
            for (i = 0; i < 8; i = i + 1) begin
               sclk = 1'b0;
               #100 sclk = 1'b1;
               #99 r = {r[6:0], sdata};
               #1;
            end
            // Closing fall releases the line; clock then rests low
            sclk = 1'b0;
            #200;
            tool_oe = 1'b1;
         end
      end
   endtask
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`include "fsa_map.vh"
module tb_top;
   reg clk, rst, standalone_mode, tool_attached, vpp, req, d, e;
   reg [2:0] op;
   reg [15:0] addr;
   reg [7:0] wdata, rd, r, cap, cap_a, runs;
   reg [31:0] lfsr;
   integer fails, n_checks, i;
   wire dout, doe, pins_free, link_mode, locked, ready, done, err, t_we, t_run, sclk, sdata;
   wire [7:0] rdata, opt, t_addr, t_data;
   fsa_flash_access u_fsa_flash_access (.clk(clk), .rst(rst), .ce(1'b1),
      .standalone_mode(standalone_mode), .tool_attached(tool_attached),
      .prog_select_voltage_pin(vpp), .link_serial_clock_pin(sclk),
      .link_serial_data_pin_i(sdata), .link_serial_data_pin_o(dout),
      .link_serial_data_pin_oe(doe), .app_link_pins_free(pins_free),
      .incircuit_link_mode(link_mode), .read_lock_active(locked), .cpu_req(req),
      .cpu_op(op), .cpu_addr(addr), .cpu_wdata(wdata), .cpu_ready(ready), .cpu_done(done),
      .cpu_err(err), .cpu_rdata(rdata), .option_byte(opt), .test_ram_we(t_we),
      .test_ram_addr(t_addr), .test_ram_data(t_data), .test_run(t_run));
   fsa_tool_model u_fsa_tool_model (.dev_o(dout), .dev_oe(doe), .sclk(sclk), .sdata(sdata));
   function [31:0] lfsr_next(input [31:0] s);
      lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task check(input [9:0] seen, input [9:0] expv);
      begin
         n_checks = n_checks + 1;
         if (seen !== expv) begin
            fails = fails + 1;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, expv);
         end
      end
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", n_checks, fails);
         if (fails == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   // Holds the request until taken, then waits for done or err
   task run(input [2:0] o, input [15:0] a, input [7:0] w, input [1:0] de, input [7:0] x);
      integer k;
      begin
         @(posedge clk);
         req <= 1'b1;
         op <= o;
         addr <= a;
         wdata <= w;
         d = 1'b0;
         while (!d) begin
            @(negedge clk);
            d = (ready === 1'b1);
            @(posedge clk);
         end
         req <= 1'b0;
         d = 1'b0;
         e = 1'b0;
         for (k = 0; k < 20000 && !(d | e); k = k + 1) begin
            @(negedge clk);
            d = (done === 1'b1);
            e = (err === 1'b1);
         end
         rd = (o == `FSA_OP_READ && d) ? rdata : 8'h00;
         check({d, e, rd}, {de, x});
      end
   endtask
   task arm;
      begin
         run(`FSA_OP_KEY, 16'h0000, `FSA_KEY1, 2'b10, 8'h00);
         run(`FSA_OP_KEY, 16'h0000, `FSA_KEY2, 2'b10, 8'h00);
      end
   endtask
   // Tool owns reset and picks the link mode by the voltage strap
   task do_reset(input v);
      begin
         rst <= 1'b1;
         vpp <= v;
         repeat (16) @(posedge clk);
         rst <= 1'b0;
         repeat (8) @(posedge clk);
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (t_we === 1'b1) begin
         cap <= t_data;
         cap_a <= t_addr;
      end
      if (t_run === 1'b1) begin
         runs <= runs + 8'h01;
      end
   end
   initial begin
      #1500000;
      fails = fails + 1;
      tally_and_finish;
   end
   initial begin
      {rst, standalone_mode, tool_attached, vpp, req, op, addr, wdata} = 0;
      rst = 1'b1;
      cap = 8'h00;
      cap_a = 8'h00;
      runs = 8'h00;
      fails = 0;
      n_checks = 0;
      lfsr = 32'hb7c5;
      do_reset(1'b0);
      check({9'h0, link_mode}, 10'h0);
      check({9'h0, pins_free}, 10'h1);
      arm;
      run(`FSA_OP_PROG, 16'hE000, 8'h5A, 2'b01, 8'h00);
      tool_attached <= 1'b1;
      do_reset(1'b1);
      check({9'h0, link_mode}, 10'h1);
      check({9'h0, pins_free}, 10'h0);
      run(`FSA_OP_PROG, 16'hE000, 8'h5A, 2'b01, 8'h00);
      arm;
      run(`FSA_OP_PROG, 16'hE000, 8'h5A, 2'b10, 8'h00);
      run(`FSA_OP_READ, 16'hE000, 8'h00, 2'b10, 8'h5A);
      arm;
      run(`FSA_OP_PROG, 16'hF000, 8'h11, 2'b01, 8'h00);
      arm;
      run(`FSA_OP_ERASE_ALL, 16'h0000, 8'h00, 2'b01, 8'h00);
      run(`FSA_OP_READ, 16'hBFFF, 8'h00, 2'b01, 8'h00);
      run(`FSA_OP_TEST_WR, 16'h0000, 8'h00, 2'b01, 8'h00);
      run(`FSA_OP_TEST_RUN, 16'h0000, 8'h00, 2'b01, 8'h00);
      for (i = 0; i < 8; i = i + 1) begin
         lfsr = lfsr_next(lfsr);
         arm;
         run(`FSA_OP_PROG, {3'b110, lfsr[12:0]}, lfsr[23:16], 2'b10, 8'h00);
         run(`FSA_OP_READ, {3'b110, lfsr[12:0]}, 8'h00, 2'b10, lfsr[23:16]);
      end
      @(posedge clk) standalone_mode <= 1'b1;
      arm;
      run(`FSA_OP_PROG, 16'hF000, 8'hA5, 2'b10, 8'h00);
      arm;
      run(`FSA_OP_PROG, 16'hDFFF, 8'h3C, 2'b10, 8'h00);
      arm;
      run(`FSA_OP_PROG, 16'hEFFF, 8'h66, 2'b10, 8'h00);
      arm;
      run(`FSA_OP_ERASE_SEC, 16'hE000, 8'h00, 2'b10, 8'h00);
      run(`FSA_OP_READ, 16'hEFFF, 8'h00, 2'b10, `FSA_ERASED);
      run(`FSA_OP_READ, 16'hDFFF, 8'h00, 2'b10, 8'h3C);
      run(`FSA_OP_READ, 16'hF000, 8'h00, 2'b10, 8'hA5);
      u_fsa_tool_model.frame({5'h00, `FSA_OP_READ, 16'hF000, 8'h00}, 1'b1, r);
      check({2'b00, r}, 10'h0A5);
      u_fsa_tool_model.frame({5'h00, `FSA_OP_TEST_WR, 16'h0012, 8'h77}, 1'b0, r);
      repeat (12) @(posedge clk);
      check({2'b00, cap}, 10'h077);
      check({2'b00, cap_a}, 10'h012);
      u_fsa_tool_model.frame({5'h00, `FSA_OP_TEST_RUN, 16'h0000, 8'h00}, 1'b0, r);
      repeat (12) @(posedge clk);
      check({2'b00, runs}, 10'h001);
      arm;
      run(`FSA_OP_OPTION, 16'h0000, 8'h01, 2'b10, 8'h00);
      check({9'h0, locked}, 10'h1);
      check({2'b00, opt}, 10'h001);
      u_fsa_tool_model.frame({5'h00, `FSA_OP_READ, 16'hF000, 8'h00}, 1'b1, r);
      check({2'b00, r}, 10'h000);
      arm;
      u_fsa_tool_model.frame({5'h00, `FSA_OP_PROG, 16'hF000, 8'h5A}, 1'b0, r);
      repeat (12) @(posedge clk);
      run(`FSA_OP_READ, 16'hF000, 8'h00, 2'b10, 8'hA5);
      arm;
      run(`FSA_OP_OPTION, 16'h0000, 8'h00, 2'b10, 8'h00);
      run(`FSA_OP_READ, 16'hF000, 8'h00, 2'b10, `FSA_ERASED);
      run(`FSA_OP_READ, 16'hDFFF, 8'h00, 2'b10, `FSA_ERASED);
      tally_and_finish;
   end
endmodule
